// ==== rtl/obi_pkg.sv ====
// constants for the output breaker interlock
package obi_pkg;
    // clock and run-time group timing
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned BASE_SAMPLE_US = 1000;
    localparam int unsigned RTG_CLASS = 3;
    localparam int unsigned TICK_US = RTG_CLASS * BASE_SAMPLE_US;
    localparam int unsigned TICK_CYCLES_DEF = TICK_US * (CLK_HZ / 1_000_000);
    // element times in milliseconds
    localparam int unsigned ON_DELAY_MS = 4000;
    localparam int unsigned STRETCH_MS = 5000;
    localparam int unsigned CLOSE_PULSE_MS = 5000;
    localparam int unsigned MONITOR_MS = 5000;
    // least times round up, longest times round down
    localparam int unsigned ON_DELAY_TICKS_DEF =
        (ON_DELAY_MS * 1000 + TICK_US - 1) / TICK_US;
    localparam int unsigned STRETCH_TICKS_DEF = STRETCH_MS * 1000 / TICK_US;
    localparam int unsigned CLOSE_TICKS_DEF = CLOSE_PULSE_MS * 1000 / TICK_US;
    localparam int unsigned MONITOR_TICKS_DEF = MONITOR_MS * 1000 / TICK_US;
    // register map
    localparam logic [7:0] CTRL_OFS = 8'h00;
    localparam logic [7:0] STATE_OFS = 8'h04;
    localparam logic [7:0] IRQ_STAT_OFS = 8'h08;
    localparam logic [7:0] IRQ_MASK_OFS = 8'h0C;
    // control fields
    localparam int unsigned CTRL_RUN_BIT = 0;
    localparam logic [31:0] CTRL_RESET = 32'h0000_0001;
    // state fields
    localparam int unsigned ST_BRK_EN = 0;
    localparam int unsigned ST_CLOSE = 1;
    localparam int unsigned ST_FEEDBACK = 2;
    localparam int unsigned ST_OP_EN = 3;
    localparam int unsigned ST_EXT_FLT = 4;
    localparam int unsigned ST_DELAY_OUT = 5;
    localparam int unsigned ST_STRETCH = 6;
    localparam int unsigned ST_PULSE_EN = 7;
    // event bits, shared by status and mask
    localparam int unsigned EV_W = 3;
    localparam int unsigned EV_MONITOR = 0;
    localparam int unsigned EV_EXT_FAULT = 1;
    localparam int unsigned EV_TRIP = 2;
    localparam logic [2:0] EV_RESET = 3'h0;
    localparam logic [31:0] RD_ZERO = 32'h0000_0000;
endpackage

// ==== rtl/obi_interlock.sv ====
// output breaker interlock with apb registers and one interrupt
// Operation
// - all gates, delays and pulses step on one run-time group tick, class 3.
// - breaker enable is the inverse of the converter fault flag.
// - contactor request passes an on-delay of 4000 ms.
// - on-delay rising output starts a 5000 ms feedback pulse.
// - or of feedback pulse and breaker closed, two inputs tied low.
// - and of that or with contactor request, two inputs tied high.
// - the and result is the line contactor feedback.
// - operation enable follows the breaker closed input.
// - missing feedback for 5000 ms while the contactor request is held raises an event.
// - rising operation request makes a 5000 ms breaker close pulse.
// - output pulses are enabled only while the breaker closed input sampled at the last tick is set and no external fault is latched.
// - stop requests of any kind never open the breaker.
// - local breaker opening while the operation request is held latches an external fault until a fresh on.
`timescale 1ns/1ps
`default_nettype none
module obi_interlock #(
    parameter int unsigned TICK_CYCLES = obi_pkg::TICK_CYCLES_DEF,
    parameter int unsigned ON_DELAY_TICKS = obi_pkg::ON_DELAY_TICKS_DEF,
    parameter int unsigned STRETCH_TICKS = obi_pkg::STRETCH_TICKS_DEF,
    parameter int unsigned CLOSE_TICKS = obi_pkg::CLOSE_TICKS_DEF,
    parameter int unsigned MONITOR_TICKS = obi_pkg::MONITOR_TICKS_DEF,
    parameter int unsigned CNT_W = 16,
    parameter int unsigned TICK_W = 20
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic contactor_request,
    input wire logic operation_request,
    input wire logic fault_active_flag,
    input wire logic breaker_closed_input,
    output logic breaker_enable,
    output logic close_command,
    output logic line_contactor_feedback,
    output logic operation_enable,
    output logic output_pulse_enable,
    output logic external_fault,
    output logic irq
);
    if (TICK_CYCLES < 1 || TICK_CYCLES >= (64'd1 << TICK_W)
        || ON_DELAY_TICKS < 1 || STRETCH_TICKS < 1 || CLOSE_TICKS < 1
        || MONITOR_TICKS < 1 || ON_DELAY_TICKS >= (64'd1 << CNT_W)
        || STRETCH_TICKS >= (64'd1 << CNT_W)
        || CLOSE_TICKS >= (64'd1 << CNT_W)
        || MONITOR_TICKS >= (64'd1 << CNT_W))
    begin : g_bad_params
        $error("obi_interlock: counts do not fit the counter widths");
    end

    localparam logic [TICK_W-1:0] TICK_LAST = TICK_W'(TICK_CYCLES - 1);
    localparam logic [CNT_W-1:0] DLY_N = CNT_W'(ON_DELAY_TICKS);
    localparam logic [CNT_W-1:0] STR_N = CNT_W'(STRETCH_TICKS);
    localparam logic [CNT_W-1:0] CLS_N = CNT_W'(CLOSE_TICKS);
    localparam logic [CNT_W-1:0] MON_N = CNT_W'(MONITOR_TICKS);
    localparam logic [CNT_W-1:0] CNT_ZERO = '0;

    typedef struct packed {
        logic [TICK_W-1:0] tick_cnt;
        logic [CNT_W-1:0] dly_cnt;
        logic dly_out;
        logic [CNT_W-1:0] str_cnt;
        logic [CNT_W-1:0] cls_cnt;
        logic [CNT_W-1:0] mon_cnt;
        logic mon_done;
        logic op_req_prev;
        logic brk_prev;
        logic flt_prev;
        logic brk_en;
        logic feedback;
        logic op_en;
        logic ext_flt;
        logic run;
        logic [obi_pkg::EV_W-1:0] ev_stat;
        logic [obi_pkg::EV_W-1:0] ev_mask;
        logic [31:0] rdata;
    } obi_state_type;

    obi_state_type s_ff;
    obi_state_type nxt_s;
    logic tick;
    logic wr_acc;
    logic addr_ok;
    logic [31:0] state_word;

    always_comb
    begin
        addr_ok = (paddr == obi_pkg::CTRL_OFS)
            || (paddr == obi_pkg::STATE_OFS)
            || (paddr == obi_pkg::IRQ_STAT_OFS)
            || (paddr == obi_pkg::IRQ_MASK_OFS);
        state_word = obi_pkg::RD_ZERO;
        state_word[obi_pkg::ST_BRK_EN] = s_ff.brk_en;
        state_word[obi_pkg::ST_CLOSE] = (s_ff.cls_cnt != CNT_ZERO);
        state_word[obi_pkg::ST_FEEDBACK] = s_ff.feedback;
        state_word[obi_pkg::ST_OP_EN] = s_ff.op_en;
        state_word[obi_pkg::ST_EXT_FLT] = s_ff.ext_flt;
        state_word[obi_pkg::ST_DELAY_OUT] = s_ff.dly_out;
        state_word[obi_pkg::ST_STRETCH] = (s_ff.str_cnt != CNT_ZERO);
        state_word[obi_pkg::ST_PULSE_EN] = s_ff.op_en && !s_ff.ext_flt;
    end

    assign wr_acc = psel && penable && pwrite;

    always_comb
    begin
        nxt_s = s_ff;
        tick = 1'b0;
        // the group divider; clearing run freezes every element as it stands
        if (s_ff.run)
        begin
            if (s_ff.tick_cnt == TICK_LAST)
            begin
                nxt_s.tick_cnt = '0;
                tick = 1'b1;
            end
            else
            begin
                nxt_s.tick_cnt = s_ff.tick_cnt + 1'b1;
            end
        end
        if (tick)
        begin
            // stop requests are not inputs here, so they cannot trip it
            nxt_s.brk_en = !fault_active_flag;
            nxt_s.flt_prev = fault_active_flag;
            if (!contactor_request)
                nxt_s.dly_cnt = '0;
            else if (s_ff.dly_cnt != DLY_N)
                nxt_s.dly_cnt = s_ff.dly_cnt + 1'b1;
            nxt_s.dly_out = contactor_request && (nxt_s.dly_cnt == DLY_N);
            if (nxt_s.dly_out && !s_ff.dly_out && s_ff.str_cnt == CNT_ZERO)
                nxt_s.str_cnt = STR_N;
            else if (s_ff.str_cnt != CNT_ZERO)
                nxt_s.str_cnt = s_ff.str_cnt - 1'b1;
            nxt_s.feedback = ((nxt_s.str_cnt != CNT_ZERO) || breaker_closed_input
                || 1'b0 || 1'b0)
                && (contactor_request && 1'b1 && 1'b1);
            nxt_s.op_req_prev = operation_request;
            if (operation_request && !s_ff.op_req_prev
                && s_ff.cls_cnt == CNT_ZERO)
                nxt_s.cls_cnt = CLS_N;
            else if (s_ff.cls_cnt != CNT_ZERO)
                nxt_s.cls_cnt = s_ff.cls_cnt - 1'b1;
            nxt_s.op_en = breaker_closed_input;
            nxt_s.brk_prev = breaker_closed_input;
            // a fresh on clears the latch; a new opening in the same tick wins
            if (operation_request && !s_ff.op_req_prev)
                nxt_s.ext_flt = 1'b0;
            if (s_ff.brk_prev && !breaker_closed_input && operation_request)
                nxt_s.ext_flt = 1'b1;
            // the window runs again each time feedback drops; feedback ends the wait and rearms it
            if (!contactor_request || nxt_s.feedback)
            begin
                nxt_s.mon_cnt = '0;
                nxt_s.mon_done = 1'b0;
            end
            else if (!s_ff.mon_done)
            begin
                nxt_s.mon_cnt = s_ff.mon_cnt + 1'b1;
                nxt_s.mon_done = (nxt_s.mon_cnt == MON_N);
            end
        end
        // register bus; events below are applied after the clear so set wins
        if (wr_acc && paddr == obi_pkg::CTRL_OFS)
            nxt_s.run = pwdata[obi_pkg::CTRL_RUN_BIT];
        else if (wr_acc && paddr == obi_pkg::IRQ_STAT_OFS)
            nxt_s.ev_stat = s_ff.ev_stat & ~pwdata[obi_pkg::EV_W-1:0];
        else if (wr_acc && paddr == obi_pkg::IRQ_MASK_OFS)
            nxt_s.ev_mask = pwdata[obi_pkg::EV_W-1:0];
        if (nxt_s.mon_done && !s_ff.mon_done)
            nxt_s.ev_stat[obi_pkg::EV_MONITOR] = 1'b1;
        if (nxt_s.ext_flt && !s_ff.ext_flt)
            nxt_s.ev_stat[obi_pkg::EV_EXT_FAULT] = 1'b1;
        if (tick && fault_active_flag && !s_ff.flt_prev)
            nxt_s.ev_stat[obi_pkg::EV_TRIP] = 1'b1;
        // read data is taken in the setup cycle, ready in the access cycle
        if (psel && !penable && !pwrite)
        begin
            if (paddr == obi_pkg::CTRL_OFS)
                nxt_s.rdata = {31'h0000_0000, s_ff.run};
            else if (paddr == obi_pkg::STATE_OFS)
                nxt_s.rdata = state_word;
            else if (paddr == obi_pkg::IRQ_STAT_OFS)
                nxt_s.rdata = {29'h0000_0000, s_ff.ev_stat};
            else if (paddr == obi_pkg::IRQ_MASK_OFS)
                nxt_s.rdata = {29'h0000_0000, s_ff.ev_mask};
            else
                nxt_s.rdata = obi_pkg::RD_ZERO;
        end
    end

    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
        begin
            s_ff <= '0;
            s_ff.run <= obi_pkg::CTRL_RESET[obi_pkg::CTRL_RUN_BIT];
            s_ff.ev_stat <= obi_pkg::EV_RESET;
            s_ff.ev_mask <= obi_pkg::EV_RESET;
        end
        else
        begin
            s_ff <= nxt_s;
        end
    end

    assign prdata = s_ff.rdata;
    assign pready = 1'b1;
    assign pslverr = psel && penable && !addr_ok;
    assign breaker_enable = s_ff.brk_en;
    assign close_command = (s_ff.cls_cnt != CNT_ZERO);
    assign line_contactor_feedback = s_ff.feedback;
    assign operation_enable = s_ff.op_en;
    assign output_pulse_enable = s_ff.op_en && !s_ff.ext_flt;
    assign external_fault = s_ff.ext_flt;
    assign irq = |(s_ff.ev_stat & s_ff.ev_mask);

    default clocking obi_cb @(posedge pclk);
    endclocking
    default disable iff (!presetn);

    sequence seq_breaker_drops;
        tick && s_ff.brk_prev && !breaker_closed_input && operation_request;
    endsequence
    sequence seq_fault_held;
        external_fault && !output_pulse_enable;
    endsequence

    chk_group_hold: assert property (!$past(tick) |->
        $stable(line_contactor_feedback) && $stable(close_command))
        else $error("output changed outside a group tick");
    chk_breaker_trip: assert property ($past(tick) |->
        breaker_enable == !$past(fault_active_flag))
        else $error("breaker enable does not follow the fault flag");
    chk_delay_time: assert property ($rose(s_ff.dly_out) |->
        s_ff.dly_cnt == DLY_N && $past(contactor_request))
        else $error("on-delay fired before its time");
    chk_stretch_load: assert property ($rose(s_ff.str_cnt != CNT_ZERO) |->
        s_ff.str_cnt == STR_N && $rose(s_ff.dly_out))
        else $error("feedback pulse started wrongly");
    chk_feedback_gate: assert property ($past(tick) |->
        line_contactor_feedback == ($past(contactor_request)
        && ((s_ff.str_cnt != CNT_ZERO) || $past(breaker_closed_input))))
        else $error("feedback gating wrong");
    chk_op_enable: assert property ($past(tick) |->
        operation_enable == $past(breaker_closed_input))
        else $error("operation enable does not follow breaker");
    chk_close_pulse: assert property ($rose(close_command) |->
        s_ff.cls_cnt == CLS_N ##1 close_command[*8])
        else $error("close pulse length wrong");
    chk_pulse_gate: assert property ($rose(output_pulse_enable) |->
        $past(tick) && $past(breaker_closed_input))
        else $error("pulses enabled with breaker open");
    chk_ext_latch: assert property (seq_breaker_drops |=>
        seq_fault_held ##1 seq_fault_held)
        else $error("local opening did not latch the fault");
    chk_monitor_end: assert property ($rose(s_ff.mon_done) |->
        s_ff.mon_cnt == MON_N && s_ff.ev_stat[obi_pkg::EV_MONITOR]
        && !line_contactor_feedback)
        else $error("monitor window length wrong");

    // countdowns show that a new edge during a running pulse cannot reload it
    chk_close_countdown: assert property ($past(tick)
        && $past(s_ff.cls_cnt) != CNT_ZERO
        |-> s_ff.cls_cnt == $past(s_ff.cls_cnt) - 1'b1)
        else $error("close pulse reloaded or stalled");
    chk_stretch_countdown: assert property ($past(tick)
        && $past(s_ff.str_cnt) != CNT_ZERO
        |-> s_ff.str_cnt == $past(s_ff.str_cnt) - 1'b1)
        else $error("feedback pulse reloaded or stalled");
    chk_delay_clear: assert property ($past(tick)
        && !$past(contactor_request)
        |-> s_ff.dly_cnt == CNT_ZERO && !s_ff.dly_out)
        else $error("on-delay not cleared by a dropped request");

    // the breaker may drop only on a converter fault, never on a stop request
    chk_stop_no_trip: assert property ($fell(breaker_enable) |->
        $past(tick) && $past(fault_active_flag))
        else $error("breaker enable dropped without a fault");
    chk_trip_event: assert property ($past(tick)
        && $past(fault_active_flag) && !$past(s_ff.flt_prev)
        |-> s_ff.ev_stat[obi_pkg::EV_TRIP])
        else $error("converter fault did not raise its event");
    chk_fault_event: assert property ($rose(external_fault) |->
        s_ff.ev_stat[obi_pkg::EV_EXT_FAULT])
        else $error("external fault did not raise its event");
    chk_ext_clear: assert property ($fell(external_fault) |->
        $past(tick) && $past(operation_request) && !$past(s_ff.op_req_prev))
        else $error("external fault cleared without a fresh on");
endmodule
`default_nettype wire

// ==== test/obi_breaker_model.sv ====
// behavioural output-side breaker with close coil and auxiliary contact
`timescale 1ns/1ps
`default_nettype none
module obi_breaker_model (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic close_coil,
    input wire logic hold_coil,
    input wire logic local_off,
    output logic closed
);
    logic closed_ff;
    // a dropped undervoltage coil wins over a pending close
    always_ff @(posedge pclk or negedge presetn)
    begin
        if (!presetn)
            closed_ff <= 1'b0;
        else if (!hold_coil || local_off)
            closed_ff <= 1'b0;
        else if (close_coil)
            closed_ff <= 1'b1;
    end
    assign closed = closed_ff;
endmodule
`default_nettype wire

// ==== test/obi_interlock_tb.sv ====
// self-checking bench for the output breaker interlock
`timescale 1ns/1ps
`default_nettype none
module obi_interlock_tb;
    localparam int TC = 4;
    localparam int CT = 10;
    logic pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0;
    logic pwrite = 1'b0, pready, pslverr, slv_err, rq = 1'b0, oq = 1'b0;
    logic flt = 1'b0, brk, loff = 1'b0, ben, cls, fb, oen, pen, xf, irq;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0000_0000, prdata, q;
    int error_cnt = 0, check_count = 0, cyc = 0, w;
    always #25 pclk = ~pclk;
    obi_interlock #(.TICK_CYCLES(TC), .ON_DELAY_TICKS(3),
        .STRETCH_TICKS(10), .CLOSE_TICKS(CT), .MONITOR_TICKS(10))
    obi_interlock_i (.pclk(pclk), .presetn(presetn), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
        .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .contactor_request(rq), .operation_request(oq),
        .fault_active_flag(flt), .breaker_closed_input(brk),
        .breaker_enable(ben), .close_command(cls),
        .line_contactor_feedback(fb), .operation_enable(oen),
        .output_pulse_enable(pen), .external_fault(xf), .irq(irq));
    obi_breaker_model obi_breaker_model_i (.pclk(pclk), .presetn(presetn),
        .close_coil(cls), .hold_coil(ben), .local_off(loff), .closed(brk));
    task automatic wt(input int n);
        repeat (n) @(posedge pclk);
    endtask
    task automatic chk(input string nm, input logic [31:0] e,
        input logic [31:0] g);
        check_count++;
        if (g !== e)
        begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", nm, e, g);
        end
    endtask
    // one apb transfer; releases after the pready edge, then idles a cycle
    task automatic apb(input logic wr, input logic [7:0] a,
        input logic [31:0] d);
        psel <= 1'b1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        slv_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
        @(posedge pclk);
    endtask
    task automatic t_regs();
        apb(1'b0, obi_pkg::CTRL_OFS, 32'h0000_0000);
        chk("ctrl", obi_pkg::CTRL_RESET, q);
        apb(1'b0, obi_pkg::IRQ_MASK_OFS, 32'h0000_0000);
        chk("mask", 32'h0000_0000, q);
        apb(1'b0, 8'h40, 32'h0000_0000);
        chk("unmapped", {31'h0000_0000, 1'b1}, {q[30:0], slv_err});
        chk("pready", 32'h0000_0001, {31'h0, pready});
    endtask
    task automatic t_feedback_open();
        rq <= 1'b1;
        wt(8);
        chk("fb_early", 32'h0000_0000, {31'h0, fb});
        wt(24);
        chk("fb_stretch", 32'h0000_0001, {31'h0, fb});
        wt(40);
        chk("fb_after", 32'h0000_0000, {31'h0, fb});
        wt(50);
        apb(1'b0, obi_pkg::IRQ_STAT_OFS, 32'h0000_0000);
        chk("monitor", 32'h0000_0001, q & 32'h0000_0001);
        apb(1'b1, obi_pkg::IRQ_STAT_OFS, 32'h0000_0001);
        rq <= 1'b0;
    endtask
    task automatic t_close();
        oq <= 1'b1;
        w = 0;
        while (cls !== 1'b1 && w < 20)
        begin
            wt(1);
            w++;
        end
        w = 0;
        while (cls === 1'b1 && w < 100)
        begin
            wt(1);
            w++;
            if (w == 8) oq <= 1'b0;
            if (w == 16) oq <= 1'b1;
        end
        chk("close_width", CT * TC, w);
        wt(10);
        chk("op_enable", 32'h0000_0003, {30'h0, oen, pen});
        rq <= 1'b1;
        wt(10);
        chk("fb_closed", 32'h0000_0001, {31'h0, fb});
        rq <= 1'b0;
    endtask
    task automatic t_local_off();
        apb(1'b1, obi_pkg::IRQ_MASK_OFS, 32'h0000_0002);
        loff <= 1'b1;
        wt(1);
        loff <= 1'b0;
        wt(12);
        chk("ext_fault", 32'h0000_0003, {30'h0, xf, irq});
        chk("pulses_off", 32'h0000_0000, {31'h0, pen});
        apb(1'b1, obi_pkg::IRQ_STAT_OFS, 32'h0000_0002);
        chk("irq_clear", 32'h0000_0000, {31'h0, irq});
        oq <= 1'b0;
        wt(8);
        oq <= 1'b1;
        wt(60);
        chk("reclosed", 32'h0000_0002, {30'h0, brk, xf});
    endtask
    task automatic t_trip();
        flt <= 1'b1;
        wt(12);
        chk("trip", 32'h0000_0000, {30'h0, ben, brk});
        apb(1'b0, obi_pkg::IRQ_STAT_OFS, 32'h0000_0000);
        chk("trip_stat", 32'h0000_0004, q & 32'h0000_0004);
        flt <= 1'b0;
    endtask
    // state word readback, then a frozen group must not react to a fault
    task automatic t_freeze();
        logic [31:0] e;
        e = 32'h0000_0000;
        e[obi_pkg::ST_BRK_EN] = 1'b1;
        e[obi_pkg::ST_EXT_FLT] = 1'b1;
        wt(12);
        apb(1'b0, obi_pkg::STATE_OFS, 32'h0000_0000);
        chk("state", e, q);
        apb(1'b1, obi_pkg::CTRL_OFS, 32'h0000_0000);
        flt <= 1'b1;
        wt(20);
        apb(1'b0, obi_pkg::CTRL_OFS, 32'h0000_0000);
        chk("frozen", 32'h0000_0001, {31'h0, ben});
        chk("run_off", 32'h0000_0000, q);
        apb(1'b1, obi_pkg::CTRL_OFS, 32'h0000_0001);
        wt(12);
        chk("resumed", 32'h0000_0000, {31'h0, ben});
        flt <= 1'b0;
    endtask
    task automatic wrap_up();
        $display("checks %0d errors %0d", check_count, error_cnt);
        if (error_cnt == 0 && check_count > 0)
            $display("bench passed");
        else
            $display("bench failed");
        $finish;
    endtask
    // generous ceiling: the whole sequence needs well under a thousand
    always @(posedge pclk)
    begin
        cyc++;
        if (cyc == 5000)
        begin
            error_cnt++;
            wrap_up();
        end
    end
    initial
    begin
        wt(2);
        presetn <= 1'b1;
        wt(1);
        t_regs();
        t_feedback_open();
        t_close();
        t_local_off();
        t_trip();
        t_freeze();
        wrap_up();
    end
endmodule
`default_nettype wire
